// File: rtl/gateway_pkg.sv
// constants shared by the i/o gateway: opcodes, modes, line map, timing
// assumes a single 40 MHz clock and a command stream already unpacked from usb
package gateway_pkg;
   // clock and spi rates, half periods derived from them
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned SPI_HZ_0 = 62_500;
   localparam int unsigned SPI_HZ_1 = 500_000;
   localparam int unsigned SPI_HZ_2 = 1_000_000;
   localparam int unsigned SPI_HZ_3 = 2_000_000;
   localparam logic [8:0] SPI_HALF_0 = 9'(CLK_HZ / (2 * SPI_HZ_0));
   localparam logic [8:0] SPI_HALF_1 = 9'(CLK_HZ / (2 * SPI_HZ_1));
   localparam logic [8:0] SPI_HALF_2 = 9'(CLK_HZ / (2 * SPI_HZ_2));
   localparam logic [8:0] SPI_HALF_3 = 9'(CLK_HZ / (2 * SPI_HZ_3));
   // lcd enable pulse width, least time so rounded up
   localparam int unsigned LCD_EN_NS = 500;
   localparam logic [4:0] LCD_EN_CYC = 5'((LCD_EN_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
   // command opcodes
   localparam logic [3:0] OP_DIR_A = 4'h0;
   localparam logic [3:0] OP_DIR_B = 4'h1;
   localparam logic [3:0] OP_WR_A = 4'h2;
   localparam logic [3:0] OP_WR_B = 4'h3;
   localparam logic [3:0] OP_SET_A = 4'h4;
   localparam logic [3:0] OP_SET_B = 4'h5;
   localparam logic [3:0] OP_RD_A = 4'h6;
   localparam logic [3:0] OP_RD_B = 4'h7;
   localparam logic [3:0] OP_MODE = 4'h8;
   localparam logic [3:0] OP_SPI_RATE = 4'h9;
   localparam logic [3:0] OP_SPI_XFER = 4'ha;
   localparam logic [3:0] OP_LCD_DATA = 4'hb;
   localparam logic [3:0] OP_LCD_CTRL = 4'hc;
   localparam logic [3:0] OP_STEP = 4'hd;
   localparam logic [3:0] OP_TWI = 4'he;
   // pin-sharing modes
   localparam logic [2:0] MODE_GPIO = 3'h0;
   localparam logic [2:0] MODE_SPI_M = 3'h1;
   localparam logic [2:0] MODE_SPI_S = 3'h2;
   localparam logic [2:0] MODE_TWI = 3'h3;
   localparam logic [2:0] MODE_STEP = 3'h4;
   // response source tags
   localparam logic [1:0] SRC_PORTA = 2'h0;
   localparam logic [1:0] SRC_PORTB = 2'h1;
   localparam logic [1:0] SRC_SPI_M = 2'h2;
   localparam logic [1:0] SRC_SPI_S = 2'h3;
   // port a line assignments
   localparam int unsigned LINE_LCD_RS = 0;
   localparam int unsigned LINE_LCD_EN = 1;
   localparam int unsigned LINE_TWI_CLK = 2;
   localparam int unsigned LINE_TWI_DAT = 3;
   localparam int unsigned LINE_SS = 4;
   localparam int unsigned LINE_MOSI = 5;
   localparam int unsigned LINE_MISO = 6;
   localparam int unsigned LINE_SCK = 7;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [7:0] ALL_OUT = 8'hff;
   typedef enum logic [1:0] {ST_IDLE, ST_SPI, ST_LCD, ST_PUSH} state_e;
endpackage

// File: rtl/resp_fifo.sv
// response buffer: parameterised width and depth, valid/ready both sides
// assumes depth is a power of two; synchronous active-high reset
`timescale 1ns/1ps
module resp_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   // full and empty straight from the occupancy count
   assign in_ready_out = (count_r != (AW + 1)'(DEPTH));
   assign out_valid_out = (count_r != '0);
   assign out_data_out = mem[rd_ptr_r];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   // storage, no reset needed on the data words
   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data_in;
      end
   end

   // pointers and count
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

// File: rtl/io_gateway.sv
// command-driven i/o gateway: two 8-bit ports, spi master/slave, lcd, stepper, two-wire
// assumes usb framing is done outside and delivers commands on the cmd_* port
`timescale 1ns/1ps
module io_gateway #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic cmd_valid_in,
   output logic cmd_ready_out,
   input wire logic [3:0] cmd_op_in,
   input wire logic [7:0] cmd_arg_in,
   input wire logic [7:0] cmd_mask_in,
   output logic resp_valid_out,
   input wire logic resp_ready_in,
   output logic [7:0] resp_data_out,
   output logic [1:0] resp_src_out,
   input wire logic [7:0] porta_in,
   output logic [7:0] porta_out,
   output logic [7:0] porta_oe_out,
   input wire logic [7:0] portb_in,
   output logic [7:0] portb_out,
   output logic [7:0] portb_oe_out,
   output logic slave_overrun_out
);
   gateway_pkg::state_e state_r;
   logic cmd_ready_r, accept, half_done, spi_done;
   logic [7:0] dir_a_r, dir_b_r, out_a_r, out_b_r, step_r;
   logic [2:0] mode_r;
   logic [1:0] rate_r;
   logic twi_scl_r, twi_sda_r, sclk_r, lcd_rs_r, sck_prev_r, slave_push, overrun_r;
   logic [9:0] pend_r, fifo_in_data, fifo_out_data;
   logic [8:0] half, div_r;
   logic [2:0] bit_r, sl_cnt_r;
   logic [7:0] tx_r, rx_r, lcd_byte_r;
   logic [4:0] lcd_cnt_r;
   logic [6:0] sl_rx_r;
   logic fifo_in_valid, fifo_in_ready;
   logic [7:0] pa_out_nxt, pa_oe_nxt, pb_out_nxt, pb_oe_nxt;

   // ready only in idle, so a command is taken on a single edge
   assign accept = cmd_valid_in && cmd_ready_r;
   assign cmd_ready_out = cmd_ready_r;
   assign slave_overrun_out = overrun_r;

   // host-visible configuration and port latches
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         dir_a_r <= gateway_pkg::BYTE_RST;
         dir_b_r <= gateway_pkg::BYTE_RST;
         out_a_r <= gateway_pkg::BYTE_RST;
         out_b_r <= gateway_pkg::BYTE_RST;
         mode_r <= gateway_pkg::MODE_GPIO;
         rate_r <= 2'h0;
         step_r <= gateway_pkg::BYTE_RST;
         twi_scl_r <= 1'b1;
         twi_sda_r <= 1'b1;
      end else if (accept) begin
         unique case (cmd_op_in)
            gateway_pkg::OP_DIR_A: dir_a_r <= cmd_arg_in;
            gateway_pkg::OP_DIR_B: dir_b_r <= cmd_arg_in;
            gateway_pkg::OP_WR_A: out_a_r <= cmd_arg_in;
            gateway_pkg::OP_WR_B: out_b_r <= cmd_arg_in;
            gateway_pkg::OP_SET_A: out_a_r <= (out_a_r & ~cmd_mask_in) | (cmd_arg_in & cmd_mask_in);
            gateway_pkg::OP_SET_B: out_b_r <= (out_b_r & ~cmd_mask_in) | (cmd_arg_in & cmd_mask_in);
            gateway_pkg::OP_MODE: mode_r <= cmd_arg_in[2:0];
            gateway_pkg::OP_SPI_RATE: rate_r <= cmd_arg_in[1:0];
            gateway_pkg::OP_STEP: step_r <= cmd_arg_in;
            gateway_pkg::OP_TWI: begin
               twi_scl_r <= cmd_arg_in[0];
               twi_sda_r <= cmd_arg_in[1];
            end
            default: ;
         endcase
      end
   end

   // half-period select; rate is latched, so it holds across transfers
   always_comb begin
      unique case (rate_r)
         2'h0: half = gateway_pkg::SPI_HALF_0;
         2'h1: half = gateway_pkg::SPI_HALF_1;
         2'h2: half = gateway_pkg::SPI_HALF_2;
         2'h3: half = gateway_pkg::SPI_HALF_3;
      endcase
   end
   assign half_done = (div_r == half - 9'h001);
   assign spi_done = (state_r == gateway_pkg::ST_SPI) && half_done && sclk_r && (bit_r == gateway_pkg::LAST_BIT);

   // command sequencer; a pending answer waits for buffer room
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         state_r <= gateway_pkg::ST_IDLE;
         cmd_ready_r <= 1'b1;
         pend_r <= '0;
      end else begin
         unique case (state_r)
            gateway_pkg::ST_IDLE: begin
               if (accept) begin
                  if (cmd_op_in == gateway_pkg::OP_RD_A) begin
                     pend_r <= {gateway_pkg::SRC_PORTA, porta_in};
                     state_r <= gateway_pkg::ST_PUSH;
                     cmd_ready_r <= 1'b0;
                  end else if (cmd_op_in == gateway_pkg::OP_RD_B) begin
                     pend_r <= {gateway_pkg::SRC_PORTB, portb_in};
                     state_r <= gateway_pkg::ST_PUSH;
                     cmd_ready_r <= 1'b0;
                  end else if (cmd_op_in == gateway_pkg::OP_SPI_XFER && mode_r == gateway_pkg::MODE_SPI_M) begin
                     state_r <= gateway_pkg::ST_SPI;
                     cmd_ready_r <= 1'b0;
                  end else if (cmd_op_in == gateway_pkg::OP_LCD_DATA || cmd_op_in == gateway_pkg::OP_LCD_CTRL) begin
                     state_r <= gateway_pkg::ST_LCD;
                     cmd_ready_r <= 1'b0;
                  end
               end
            end
            gateway_pkg::ST_SPI: begin
               if (spi_done) begin
                  pend_r <= {gateway_pkg::SRC_SPI_M, rx_r};
                  state_r <= gateway_pkg::ST_PUSH;
               end
            end
            gateway_pkg::ST_LCD: begin
               if (lcd_cnt_r == gateway_pkg::LCD_EN_CYC - 5'h01) begin
                  state_r <= gateway_pkg::ST_IDLE;
                  cmd_ready_r <= 1'b1;
               end
            end
            gateway_pkg::ST_PUSH: begin
               if (!slave_push && fifo_in_ready) begin
                  state_r <= gateway_pkg::ST_IDLE;
                  cmd_ready_r <= 1'b1;
               end
            end
         endcase
      end
   end

   // spi master engine, mode 0: drive on fall, sample on rise
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         div_r <= '0;
         bit_r <= '0;
         sclk_r <= 1'b0;
         tx_r <= gateway_pkg::BYTE_RST;
         rx_r <= gateway_pkg::BYTE_RST;
      end else if (accept && cmd_op_in == gateway_pkg::OP_SPI_XFER) begin
         tx_r <= cmd_arg_in;
         div_r <= '0;
         bit_r <= '0;
         sclk_r <= 1'b0;
      end else if (state_r == gateway_pkg::ST_SPI) begin
         if (half_done) begin
            div_r <= '0;
            sclk_r <= !sclk_r;
            if (!sclk_r) begin
               rx_r <= {rx_r[6:0], porta_in[gateway_pkg::LINE_MISO]};
            end else begin
               tx_r <= {tx_r[6:0], 1'b0};
               bit_r <= bit_r + 3'h1;
            end
         end else begin
            div_r <= div_r + 9'h001;
         end
      end
   end

   // lcd cycle: byte on port b, rs and enable on port a lines 0 and 1
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         lcd_cnt_r <= '0;
         lcd_byte_r <= gateway_pkg::BYTE_RST;
         lcd_rs_r <= 1'b0;
      end else if (accept) begin
         lcd_cnt_r <= '0;
         lcd_byte_r <= cmd_arg_in;
         lcd_rs_r <= (cmd_op_in == gateway_pkg::OP_LCD_DATA);
      end else if (state_r == gateway_pkg::ST_LCD) begin
         lcd_cnt_r <= lcd_cnt_r + 5'h01;
      end
   end

   // spi slave receiver; inputs are taken as synchronous to sys_clk
   assign slave_push = (mode_r == gateway_pkg::MODE_SPI_S) && !porta_in[gateway_pkg::LINE_SS]
      && porta_in[gateway_pkg::LINE_SCK] && !sck_prev_r && (sl_cnt_r == gateway_pkg::LAST_BIT);
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         sck_prev_r <= 1'b0;
         sl_cnt_r <= '0;
         sl_rx_r <= '0;
      end else begin
         sck_prev_r <= porta_in[gateway_pkg::LINE_SCK];
         if (mode_r != gateway_pkg::MODE_SPI_S || porta_in[gateway_pkg::LINE_SS]) begin
            sl_cnt_r <= '0; // deselect realigns the byte boundary
         end else if (porta_in[gateway_pkg::LINE_SCK] && !sck_prev_r) begin
            sl_cnt_r <= sl_cnt_r + 3'h1;
            sl_rx_r <= {sl_rx_r[5:0], porta_in[gateway_pkg::LINE_MOSI]};
         end
      end
   end

   // a slave byte that finds the buffer full is dropped and flagged; set beats clear
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         overrun_r <= 1'b0;
      end else if (slave_push && !fifo_in_ready) begin
         overrun_r <= 1'b1;
      end else if (accept && cmd_op_in == gateway_pkg::OP_MODE) begin
         overrun_r <= 1'b0;
      end
   end

   // slave bytes take priority: the external master cannot be stalled
   assign fifo_in_valid = slave_push || (state_r == gateway_pkg::ST_PUSH);
   assign fifo_in_data = slave_push ? {gateway_pkg::SRC_SPI_S, sl_rx_r, porta_in[gateway_pkg::LINE_MOSI]} : pend_r;

   resp_fifo #(
      .WIDTH(10),
      .DEPTH(FIFO_DEPTH)
   ) u_resp_fifo (
      .sys_clk_in(sys_clk_in),
      .srst_in(srst_in),
      .in_valid_in(fifo_in_valid),
      .in_ready_out(fifo_in_ready),
      .in_data_in(fifo_in_data),
      .out_valid_out(resp_valid_out),
      .out_ready_in(resp_ready_in),
      .out_data_out(fifo_out_data)
   );
   assign resp_data_out = fifo_out_data[7:0];
   assign resp_src_out = fifo_out_data[9:8];

   // pin sharing; lines a mode does not claim stay general-purpose
   always_comb begin
      pa_out_nxt = out_a_r;
      pa_oe_nxt = dir_a_r;
      pb_out_nxt = out_b_r;
      pb_oe_nxt = dir_b_r;
      unique case (mode_r)
         gateway_pkg::MODE_SPI_M: begin
            pa_out_nxt[gateway_pkg::LINE_MOSI] = tx_r[7];
            pa_oe_nxt[gateway_pkg::LINE_MOSI] = 1'b1;
            pa_oe_nxt[gateway_pkg::LINE_MISO] = 1'b0;
            pa_out_nxt[gateway_pkg::LINE_SCK] = sclk_r;
            pa_oe_nxt[gateway_pkg::LINE_SCK] = 1'b1;
         end
         gateway_pkg::MODE_SPI_S: begin
            pa_oe_nxt[gateway_pkg::LINE_SS] = 1'b0;
            pa_oe_nxt[gateway_pkg::LINE_MOSI] = 1'b0;
            pa_oe_nxt[gateway_pkg::LINE_SCK] = 1'b0;
            pa_out_nxt[gateway_pkg::LINE_MISO] = 1'b0; // no reply data, reads as zero
            pa_oe_nxt[gateway_pkg::LINE_MISO] = 1'b1;
         end
         gateway_pkg::MODE_TWI: begin
            pa_out_nxt[gateway_pkg::LINE_TWI_CLK] = 1'b0; // open drain: only pulls low
            pa_oe_nxt[gateway_pkg::LINE_TWI_CLK] = !twi_scl_r;
            pa_out_nxt[gateway_pkg::LINE_TWI_DAT] = 1'b0;
            pa_oe_nxt[gateway_pkg::LINE_TWI_DAT] = !twi_sda_r;
         end
         gateway_pkg::MODE_STEP: begin
            pa_out_nxt = step_r;
            pa_oe_nxt = gateway_pkg::ALL_OUT;
         end
         default: ;
      endcase
      if (state_r == gateway_pkg::ST_LCD) begin
         pb_out_nxt = lcd_byte_r;
         pb_oe_nxt = gateway_pkg::ALL_OUT;
         pa_out_nxt[gateway_pkg::LINE_LCD_RS] = lcd_rs_r;
         pa_oe_nxt[gateway_pkg::LINE_LCD_RS] = 1'b1;
         pa_out_nxt[gateway_pkg::LINE_LCD_EN] = 1'b1;
         pa_oe_nxt[gateway_pkg::LINE_LCD_EN] = 1'b1;
      end
   end

   // pins are registered to keep them glitch-free
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         porta_out <= gateway_pkg::BYTE_RST;
         porta_oe_out <= gateway_pkg::BYTE_RST;
         portb_out <= gateway_pkg::BYTE_RST;
         portb_oe_out <= gateway_pkg::BYTE_RST;
      end else begin
         porta_out <= pa_out_nxt;
         porta_oe_out <= pa_oe_nxt;
         portb_out <= pb_out_nxt;
         portb_oe_out <= pb_oe_nxt;
      end
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);

   chk_dir_whole_port: assert property (accept && cmd_op_in == gateway_pkg::OP_DIR_B
      |=> ##1 (portb_oe_out == $past(cmd_arg_in, 2)) || $past(state_r) == gateway_pkg::ST_LCD)
      else $error("port b direction not applied");
   chk_port_read: assert property (accept && cmd_op_in == gateway_pkg::OP_RD_B
      |=> state_r == gateway_pkg::ST_PUSH && pend_r == {gateway_pkg::SRC_PORTB, $past(portb_in)})
      else $error("port b read value wrong");
   chk_rate_hold: assert property (!(accept && cmd_op_in == gateway_pkg::OP_SPI_RATE) |=> $stable(rate_r))
      else $error("spi rate changed without command");
   chk_sclk_half: assert property (state_r == gateway_pkg::ST_SPI && $changed(sclk_r)
      |=> !$changed(sclk_r) [*8])
      else $error("spi clock half period too short");
   chk_spi_pins: assert property (mode_r == gateway_pkg::MODE_SPI_M && state_r != gateway_pkg::ST_LCD
      |=> porta_oe_out[7] && !porta_oe_out[6] && porta_oe_out[5] && porta_out[7] == $past(sclk_r))
      else $error("spi master pin map wrong");
   chk_slave_select: assert property (mode_r == gateway_pkg::MODE_SPI_S |=> !porta_oe_out[4] && !porta_oe_out[7])
      else $error("slave select line driven");
   chk_slave_store: assert property (slave_push |=> resp_valid_out || overrun_r)
      else $error("slave byte neither stored nor flagged");
   chk_twi_lines: assert property (mode_r == gateway_pkg::MODE_TWI && state_r != gateway_pkg::ST_LCD
      |=> porta_oe_out[2] == !$past(twi_scl_r) && porta_oe_out[3] == !$past(twi_sda_r) && !porta_out[2])
      else $error("two-wire lines wrong");
   chk_step_drive: assert property (mode_r == gateway_pkg::MODE_STEP && state_r != gateway_pkg::ST_LCD
      |=> porta_oe_out == gateway_pkg::ALL_OUT && porta_out == $past(step_r))
      else $error("stepper pattern not driven");
   chk_lcd_pulse: assert property ($rose(state_r == gateway_pkg::ST_LCD) |-> (state_r == gateway_pkg::ST_LCD) [*8])
      else $error("lcd enable pulse too short");
endmodule

// File: verif/spi_peer.sv
// spi peripheral model on port a: mode 0, msb first, fixed reply byte
// assumes its select is a plain gateway output on line 4
`timescale 1ns/1ps
module spi_peer (
   input wire logic sclk_in,
   input wire logic mosi_in,
   input wire logic sel_n_in,
   input wire logic [7:0] reply_in,
   output logic miso_out,
   output logic [7:0] got_out
);
   logic [2:0] cnt_r;
   // bit count restarts whenever select is released
   always @(posedge sclk_in or posedge sel_n_in) begin
      if (sel_n_in) begin
         cnt_r <= 3'h0;
      end else begin
         got_out <= {got_out[6:0], mosi_in};
         cnt_r <= cnt_r + 3'h1;
      end
   end
   // released line shows the inverse of the last bit, never a held value
   assign miso_out = sel_n_in ? ~reply_in[0] : reply_in[3'h7 - cnt_r];
endmodule

// File: verif/tb_top.sv
// self-checking bench for the i/o gateway: ports, spi both ways, lcd, two-wire, stepper, fifo
// assumes the spi peer model; the bench itself plays the external spi master
`timescale 1ns/1ps
module tb_top;
   logic sys_clk, srst, cmd_valid, cmd_ready, resp_valid, resp_ready, overrun, miso;
   logic [3:0] cmd_op;
   logic [7:0] cmd_arg, cmd_mask, resp_data, pa_out, pa_oe, pb_out, pb_oe, pa_ext, pb_ext;
   logic [7:0] pa_wire, pb_wire, reply, got;
   logic [1:0] resp_src;
   int error_cnt, compares;
   // wire levels: driven lines win, else peer miso or bench level
   assign pa_wire = (pa_oe & pa_out) | (~pa_oe & {pa_ext[7], miso, pa_ext[5:0]});
   assign pb_wire = (pb_oe & pb_out) | (~pb_oe & pb_ext);
   io_gateway i_io_gateway (.sys_clk_in(sys_clk), .srst_in(srst), .cmd_valid_in(cmd_valid),
      .cmd_ready_out(cmd_ready), .cmd_op_in(cmd_op), .cmd_arg_in(cmd_arg), .cmd_mask_in(cmd_mask),
      .resp_valid_out(resp_valid), .resp_ready_in(resp_ready), .resp_data_out(resp_data),
      .resp_src_out(resp_src), .porta_in(pa_wire), .porta_out(pa_out), .porta_oe_out(pa_oe),
      .portb_in(pb_wire), .portb_out(pb_out), .portb_oe_out(pb_oe), .slave_overrun_out(overrun));
   spi_peer i_spi_peer (.sclk_in(pa_wire[7]), .mosi_in(pa_wire[5]), .sel_n_in(pa_wire[4]),
      .reply_in(reply), .miso_out(miso), .got_out(got));
   // 40 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task tick;
      @(posedge sys_clk);
      #1;
   endtask
   task final_report;
      $display("errors=%0d compares=%0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task hang;
      error_cnt++;
      final_report;
   endtask
   // one idle cycle after each command so valid never toggles twice in a step
   task send(input logic [3:0] op, input logic [7:0] arg, input logic [7:0] mask = 8'h00);
      int n;
      n = 0;
      cmd_op = op;
      cmd_arg = arg;
      cmd_mask = mask;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) begin
         n++;
         if (n > 8000) hang;
         tick;
      end
      tick;
      cmd_valid = 1'b0;
      tick;
   endtask
   task get_resp(input logic [7:0] d, input logic [1:0] s);
      int n;
      n = 0;
      while (resp_valid !== 1'b1) begin
         n++;
         if (n > 8000) hang;
         tick;
      end
      check(resp_data, d);
      check(resp_src, s);
      resp_ready = 1'b1;
      tick;
      resp_ready = 1'b0;
      tick;
   endtask
   task t_gpio;
      send(gateway_pkg::OP_DIR_A, 8'hf0);
      send(gateway_pkg::OP_DIR_B, 8'h0f);
      send(gateway_pkg::OP_WR_B, 8'ha5);
      send(gateway_pkg::OP_WR_A, 8'h20);
      send(gateway_pkg::OP_SET_A, 8'hff, 8'h50);
      pb_ext = 8'h3c;
      pa_ext = 8'h1a;
      check(pa_oe, 8'hf0);
      check(pb_oe, 8'h0f);
      check(pb_out & 8'h0f, 8'h05);
      check(pa_out & 8'hf0, 8'h70);
      send(gateway_pkg::OP_RD_B, 8'h00);
      get_resp(8'h35, gateway_pkg::SRC_PORTB);
      send(gateway_pkg::OP_RD_A, 8'h00);
      get_resp(8'h7a, gateway_pkg::SRC_PORTA);
      send(gateway_pkg::OP_SET_B, 8'h00, 8'h01);
      check(pb_out & 8'h0f, 8'h04);
   endtask
   task t_lcd;
      send(gateway_pkg::OP_LCD_DATA, 8'h41);
      check({pb_oe, pb_out}, 16'hff41);
      check(pa_out[1:0], 2'h3);
      check(cmd_ready, 1'b0);
      send(gateway_pkg::OP_LCD_CTRL, 8'h01);
      check({pa_out[1:0], pb_out}, 10'h201);
   endtask
   // rate order 3..0 then one more transfer with no new rate
   task t_spi_m;
      int n, cnt;
      logic [1:0] r;
      logic [8:0] half [4];
      half = '{9'h140, 9'h028, 9'h014, 9'h00a};
      send(gateway_pkg::OP_MODE, 8'h01);
      send(gateway_pkg::OP_SET_A, 8'h00, 8'h10);
      reply = 8'hc5;
      for (int i = 0; i < 5; i++) begin
         r = (i < 4) ? 2'(3 - i) : 2'h0;
         if (i < 4) send(gateway_pkg::OP_SPI_RATE, {6'h00, r});
         send(gateway_pkg::OP_SPI_XFER, 8'h3c ^ 8'(i));
         check(pa_oe[7:5], 3'h5);
         n = 0;
         while (pa_out[7] !== 1'b1) begin
            n++;
            if (n > 8000) hang;
            tick;
         end
         cnt = 0;
         while (pa_out[7] === 1'b1 && cnt < 1000) begin
            cnt++;
            tick;
         end
         check(16'(cnt), 16'(half[r]));
         get_resp(8'hc5, gateway_pkg::SRC_SPI_M);
         check(got, 8'h3c ^ 8'(i));
      end
   endtask
   task t_pins;
      send(gateway_pkg::OP_MODE, 8'h03);
      send(gateway_pkg::OP_TWI, 8'h01);
      check({pa_oe[3:2], pa_out[3]}, 3'h4);
      send(gateway_pkg::OP_MODE, 8'h04);
      send(gateway_pkg::OP_STEP, 8'h96);
      send(gateway_pkg::OP_SPI_XFER, 8'h11);
      check({pa_oe, pa_out}, 16'hff96);
      repeat (20) tick;
      check(resp_valid, 1'b0);
   endtask
   // bench acts as external master: select, eight bits msb first, deselect
   // clock high 3 cycles and low 4, so each phase is seen on at least two edges
   task sl_byte(input logic [7:0] b);
      pa_ext[4] = 1'b0;
      tick;
      for (int i = 7; i >= 0; i--) begin
         pa_ext[5] = b[i];
         repeat (3) tick;
         pa_ext[7] = 1'b1;
         repeat (3) tick;
         pa_ext[7] = 1'b0;
         tick;
      end
      pa_ext[4] = 1'b1;
   endtask
   task t_spi_s;
      send(gateway_pkg::OP_MODE, 8'h02);
      sl_byte(8'h9b);
      check(pa_oe[4], 1'b0);
      get_resp(8'h9b, gateway_pkg::SRC_SPI_S);
   endtask
   // fill the response buffer with the host stalled, then drain it dry
   // a slave byte arriving on the full buffer must be dropped and flagged
   task t_fifo;
      pb_ext = 8'h5a;
      send(gateway_pkg::OP_DIR_B, 8'h00);
      send(gateway_pkg::OP_MODE, 8'h02);
      for (int i = 0; i < 16; i++) send(gateway_pkg::OP_RD_B, 8'h00);
      sl_byte(8'h66);
      check(overrun, 1'b1);
      for (int i = 0; i < 16; i++) get_resp(8'h5a, gateway_pkg::SRC_PORTB);
      check(resp_valid, 1'b0);
      send(gateway_pkg::OP_MODE, 8'h00);
      check({resp_valid, overrun}, 2'h0);
   endtask
   // reset, then every scenario in turn
   initial begin
      srst = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = 4'h0;
      cmd_arg = 8'h00;
      cmd_mask = 8'h00;
      resp_ready = 1'b0;
      pa_ext = 8'h10;
      pb_ext = 8'h00;
      reply = 8'h00;
      error_cnt = 0;
      compares = 0;
      repeat (16) tick;
      srst = 1'b0;
      check({pa_oe, pb_oe}, 16'h0000);
      t_gpio;
      t_lcd;
      t_spi_m;
      t_pins;
      t_spi_s;
      t_fifo;
      final_report;
   end
endmodule
